// *** design/pxc_defs.svh ***
// Offsets, field positions and reset values of the crossover control register
`ifndef PXC_DEFS_SVH
`define PXC_DEFS_SVH

`define PXC_REG_INDEX      5'h1b
`define PXC_DATA_W         16
`define PXC_ADDR_W         5
`define PXC_BIT_SRC_SEL    15
`define PXC_BIT_AUTO_EN    14
`define PXC_BIT_MAN_STATE  13
`define PXC_BIT_HB_OFF     11
`define PXC_BIT_PLL_LOCK   10
`define PXC_BIT_RX_POL     4
`define PXC_RESET_VAL      16'h0000
`define PXC_WRITE_MASK     16'hec00
`define PXC_SOFT_RST_MASK  16'h6c00

`endif

// *** design/pxc_pkg.sv ***
// Types shared by the crossover control register block
package pxc_pkg;

    // Gray order: straight -> crossover -> automatic
    typedef enum logic [1:0]
    {
        PXC_MDI_STRAIGHT = 2'h0,
        PXC_MDI_CROSS    = 2'h1,
        PXC_MDI_AUTO     = 2'h3
    } pxc_mdix_mode_t;

    typedef struct packed
    {
        logic        read;
        logic        write;
        logic [4:0]  phyAddr;
        logic [4:0]  regAddr;
        logic [15:0] wrData;
    } pxc_mgmt_req_t;

    typedef struct packed
    {
        logic srcSel;
        logic autoEn;
        logic manualState;
        logic heartbeatOff;
        logic pllRefLock;
    } pxc_ctrl_t;

endpackage : pxc_pkg

// *** design/pxc_mode_decode.sv ***
// Crossover mode decode from register bits or latched straps
`timescale 1ns/1ps

module pxc_mode_decode
(
    input  wire logic                    srcSel,
    input  wire logic                    autoEn,
    input  wire logic                    manualState,
    input  wire logic                    autoStrap,
    input  wire logic                    manualStrap,
    output pxc_pkg::pxc_mdix_mode_t      mode,
    output logic                         reservedSel
);

    always_comb
    begin
        reservedSel = 1'b0;
        if (srcSel)
        begin
            case ({autoEn, manualState})
                2'b00:   mode = pxc_pkg::PXC_MDI_STRAIGHT;
                2'b01:   mode = pxc_pkg::PXC_MDI_CROSS;
                2'b10:   mode = pxc_pkg::PXC_MDI_AUTO;
                default:
                begin
                    // Forbidden pair: fall back to a safe straight link
                    mode        = pxc_pkg::PXC_MDI_STRAIGHT;
                    reservedSel = 1'b1;
                end
            endcase
        end
        else if (autoStrap)
        begin
            mode = pxc_pkg::PXC_MDI_AUTO;
        end
        else if (manualStrap)
        begin
            mode = pxc_pkg::PXC_MDI_CROSS;
        end
        else
        begin
            mode = pxc_pkg::PXC_MDI_STRAIGHT;
        end
    end

endmodule : pxc_mode_decode

// *** design/pxc_special_ctrl.sv ***
// Per-port crossover, heartbeat and receive PLL control register
//
// Operation
// - The register sits at management index 27 and is 16 bits wide.
// - With bit 15 set, bits 14 and 13 decide crossover, straps ignored.
// - With bit 15 clear (reset value), the latched straps decide.
// - Under register control 00 straight, 01 crossover, 10 automatic.
// - Bit 11 set disables the heartbeat test; clear runs it.
// - Bit 10 set pins the 10M receive PLL to the reference, no 10M rx.
// - Read-only bit 4 shows 10BASE-T receive polarity, 1 reversed.
// - Bits 14, 13, 11, 10 clear on a port PHY reset and on reset.
// - That port reset clears them only while the basic reset bit is set.
// - Only accesses at the port's own 5-bit PHY address are answered.
`timescale 1ns/1ps
`include "pxc_defs.svh"

module pxc_special_ctrl
(
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire pxc_pkg::pxc_mgmt_req_t  mgmtReq,
    input  wire logic [4:0]              portPhyMgmtAddress,
    input  wire logic                    portPhyResetReq,
    input  wire logic                    phyBasicResetBit,
    input  wire logic                    manualCrossStrap,
    input  wire logic                    autoCrossStrap,
    input  wire logic                    rxPolarityPin,
    output logic [15:0]                  mgmtRdData,
    output logic                         mgmtRdValid,
    output pxc_pkg::pxc_mdix_mode_t      crossoverMode,
    output logic                         crossoverReservedSel,
    output logic                         heartbeatTestDisable,
    output logic                         rxPllForceRefLock,
    output logic                         rx10mBlocked
);

    // ****************************************************************
    // Access decode
    // ****************************************************************
    logic hit;
    logic wrHit;
    logic rdHit;
    logic softClr;

    assign hit   = (mgmtReq.phyAddr == portPhyMgmtAddress)
                && (mgmtReq.regAddr == `PXC_REG_INDEX);
    assign wrHit = hit && mgmtReq.write;
    assign rdHit = hit && mgmtReq.read;
    // Chip-level port reset only acts while the basic reset bit is set
    assign softClr = portPhyResetReq && phyBasicResetBit;

    // ****************************************************************
    // Polarity synchroniser
    // ****************************************************************
    logic polMeta;
    logic polSync;
    logic next_polMeta;
    logic next_polSync;

    always_comb
    begin
        next_polMeta = rxPolarityPin;
        next_polSync = polMeta;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            polMeta <= 1'b0;
            polSync <= 1'b0;
        end
        else
        begin
            polMeta <= next_polMeta;
            polSync <= next_polSync;
        end
    end

    // ****************************************************************
    // Control bits
    // ****************************************************************
    pxc_pkg::pxc_ctrl_t ctrl;
    pxc_pkg::pxc_ctrl_t next_ctrl;

    always_comb
    begin
        next_ctrl = ctrl;
        if (wrHit)
        begin
            // Only writable bits are taken; the rest are dropped
            next_ctrl.srcSel       = mgmtReq.wrData[`PXC_BIT_SRC_SEL];
            next_ctrl.autoEn       = mgmtReq.wrData[`PXC_BIT_AUTO_EN];
            next_ctrl.manualState  = mgmtReq.wrData[`PXC_BIT_MAN_STATE];
            next_ctrl.heartbeatOff = mgmtReq.wrData[`PXC_BIT_HB_OFF];
            next_ctrl.pllRefLock   = mgmtReq.wrData[`PXC_BIT_PLL_LOCK];
        end
        // Port reset beats a write landing in the same cycle on bits 14, 13, 11 and 10; bit 15 takes the write
        if (softClr)
        begin
            next_ctrl.autoEn       = 1'b0;
            next_ctrl.manualState  = 1'b0;
            next_ctrl.heartbeatOff = 1'b0;
            next_ctrl.pllRefLock   = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl <= '0;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    // ****************************************************************
    // Mode decode and outputs
    // ****************************************************************
    pxc_pkg::pxc_mdix_mode_t decMode;
    logic                    decReserved;

    pxc_mode_decode u_decode
    (
        .srcSel      (ctrl.srcSel),
        .autoEn      (ctrl.autoEn),
        .manualState (ctrl.manualState),
        .autoStrap   (autoCrossStrap),
        .manualStrap (manualCrossStrap),
        .mode        (decMode),
        .reservedSel (decReserved)
    );

    pxc_pkg::pxc_mdix_mode_t next_crossoverMode;
    logic                    next_crossoverReservedSel;
    logic [15:0]             next_mgmtRdData;
    logic                    next_mgmtRdValid;
    logic [15:0]             regImage;

    always_comb
    begin
        regImage = `PXC_RESET_VAL;
        regImage[`PXC_BIT_SRC_SEL]   = ctrl.srcSel;
        regImage[`PXC_BIT_AUTO_EN]   = ctrl.autoEn;
        regImage[`PXC_BIT_MAN_STATE] = ctrl.manualState;
        regImage[`PXC_BIT_HB_OFF]    = ctrl.heartbeatOff;
        regImage[`PXC_BIT_PLL_LOCK]  = ctrl.pllRefLock;
        regImage[`PXC_BIT_RX_POL]    = polSync;
        next_crossoverMode        = decMode;
        next_crossoverReservedSel = decReserved;
        next_mgmtRdValid          = rdHit;
        next_mgmtRdData           = rdHit ? regImage : mgmtRdData;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            crossoverMode        <= pxc_pkg::PXC_MDI_STRAIGHT;
            crossoverReservedSel <= 1'b0;
            mgmtRdValid          <= 1'b0;
            mgmtRdData           <= `PXC_RESET_VAL;
        end
        else
        begin
            crossoverMode        <= next_crossoverMode;
            crossoverReservedSel <= next_crossoverReservedSel;
            mgmtRdValid          <= next_mgmtRdValid;
            mgmtRdData           <= next_mgmtRdData;
        end
    end

    assign heartbeatTestDisable = ctrl.heartbeatOff;
    assign rxPllForceRefLock    = ctrl.pllRefLock;
    // Reference lock leaves no line clock to recover 10M data from
    assign rx10mBlocked         = ctrl.pllRefLock;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_write_capture: assert property (
        @(posedge clk) disable iff (sys_rst)
        wrHit && !softClr |=>
            ctrl.srcSel == $past(mgmtReq.wrData[`PXC_BIT_SRC_SEL])
            && ctrl.pllRefLock == $past(mgmtReq.wrData[`PXC_BIT_PLL_LOCK]))
        else $error("Write to the register not captured");

    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        mgmtRdValid |-> (mgmtRdData & ~16'hec10) == 16'h0000)
        else $error("Reserved bit reads nonzero");

    chk_reg_source: assert property (
        @(posedge clk) disable iff (sys_rst)
        ctrl.srcSel && !ctrl.autoEn && ctrl.manualState
        && $stable(ctrl) |=> crossoverMode == pxc_pkg::PXC_MDI_CROSS)
        else $error("Register crossover select ignored");

    chk_strap_source: assert property (
        @(posedge clk) disable iff (sys_rst)
        !ctrl.srcSel && autoCrossStrap
        |=> crossoverMode == pxc_pkg::PXC_MDI_AUTO)
        else $error("Strap automatic mode not followed");

    chk_auto_decode: assert property (
        @(posedge clk) disable iff (sys_rst)
        ctrl.srcSel && ctrl.autoEn && !ctrl.manualState
        |=> crossoverMode == pxc_pkg::PXC_MDI_AUTO
            && !crossoverReservedSel)
        else $error("Automatic crossover decode wrong");

    chk_heartbeat_bit: assert property (
        @(posedge clk) disable iff (sys_rst)
        mgmtRdValid
        |-> mgmtRdData[`PXC_BIT_HB_OFF] == $past(heartbeatTestDisable))
        else $error("Heartbeat disable disagrees with readback");

    chk_pll_lock: assert property (
        @(posedge clk) disable iff (sys_rst)
        wrHit && !softClr && mgmtReq.wrData[`PXC_BIT_PLL_LOCK]
        |=> rxPllForceRefLock && rx10mBlocked)
        else $error("PLL reference lock not applied");

    chk_polarity_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        mgmtRdValid |-> mgmtRdData[`PXC_BIT_RX_POL] == $past(polSync))
        else $error("Polarity readback wrong");

    chk_soft_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        softClr |=> !heartbeatTestDisable && !rxPllForceRefLock
            && !ctrl.autoEn && !ctrl.manualState)
        else $error("Port reset did not clear bits");

    chk_no_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        portPhyResetReq && !phyBasicResetBit && !wrHit
        |=> $stable(ctrl))
        else $error("Port reset acted without basic reset bit");

    chk_addr_filter: assert property (
        @(posedge clk) disable iff (sys_rst)
        mgmtReq.read && mgmtReq.phyAddr != portPhyMgmtAddress
        |=> !mgmtRdValid)
        else $error("Answered a foreign PHY address");

endmodule : pxc_special_ctrl

// *** tb/pxc_mgmt_host.sv ***
// Management host model that issues register reads and writes
`timescale 1ns/1ps

module pxc_mgmt_host
(
    input  wire logic              clk,
    output pxc_pkg::pxc_mgmt_req_t mgmtReq,
    input  wire logic [15:0]       mgmtRdData,
    input  wire logic              mgmtRdValid
);
    initial mgmtReq = '0;

    // ****************************************
    // Access tasks, driven on the falling edge
    // ****************************************
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] d);
        @(negedge clk);
        if (d[14])
            d[13] = 1'b0;
        mgmtReq = '{1'b0, 1'b1, pa, ra, d};
        @(negedge clk);
        // Released fields show the inverse, never a stale copy
        mgmtReq = '{1'b0, 1'b0, ~pa, ~ra, ~d};
    endtask : wr

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra,
                      output logic [15:0] d, output logic v);
        @(negedge clk);
        mgmtReq = '{1'b1, 1'b0, pa, ra, ~mgmtReq.wrData};
        @(negedge clk);
        d = mgmtRdData;
        v = mgmtRdValid;
        mgmtReq = '{1'b0, 1'b0, ~pa, ~ra, ~mgmtReq.wrData};
    endtask : rd
endmodule : pxc_mgmt_host

// *** tb/pxc_special_ctrl_tb_top.sv ***
// Self-checking bench for the crossover control register
`timescale 1ns/1ps

module pxc_special_ctrl_tb_top;
    logic                    clk = 1'b0;
    logic                    sysRst = 1'b1;
    pxc_pkg::pxc_mgmt_req_t  mgmtReq;
    logic [4:0]              portAddr = 5'h05;
    logic                    portRst = 1'b0, basicRst = 1'b0;
    logic                    manStrap = 1'b0, autoStrap = 1'b0, pol = 1'b0;
    logic [15:0]             rdData;
    logic                    rdValid, resSel, hbOff, pllLock, rxBlk;
    pxc_pkg::pxc_mdix_mode_t mode;
    int                      mismatches = 0, cmp_count = 0, cycles = 0;

    always #2.5 clk = ~clk;

    pxc_special_ctrl DUT
    (
        .clk(clk), .sys_rst(sysRst), .mgmtReq(mgmtReq),
        .portPhyMgmtAddress(portAddr), .portPhyResetReq(portRst),
        .phyBasicResetBit(basicRst), .manualCrossStrap(manStrap),
        .autoCrossStrap(autoStrap), .rxPolarityPin(pol),
        .mgmtRdData(rdData), .mgmtRdValid(rdValid),
        .crossoverMode(mode), .crossoverReservedSel(resSel),
        .heartbeatTestDisable(hbOff), .rxPllForceRefLock(pllLock),
        .rx10mBlocked(rxBlk)
    );

    pxc_mgmt_host host
    (
        .clk(clk), .mgmtReq(mgmtReq),
        .mgmtRdData(rdData), .mgmtRdValid(rdValid)
    );

    // ****************************************
    // Shared checks and accesses
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rdChk(input string what, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        host.rd(portAddr, 5'h1b, d, v);
        check({what, " valid"}, 16'h0001, {15'h0, v});
        check(what, exp, d);
    endtask : rdChk

    task automatic wrW(input logic [15:0] x);
        host.wr(portAddr, 5'h1b, x);
    endtask : wrW

    task automatic ctrlChk(input logic hb, input logic pll);
        check("ctrl", {13'h0, hb, pll, pll}, {13'h0, hbOff, pllLock, rxBlk});
    endtask : ctrlChk

    task automatic modeChk(input logic [1:0] exp);
        @(negedge clk);
        check("mode", {14'h0, exp}, {14'h0, mode});
        check("reserved select", 16'h0000, {15'h0, resSel});
    endtask : modeChk

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_defaults;
        rdChk("reset image", 16'h0000);
        ctrlChk(1'b0, 1'b0);
        modeChk(2'h0);
    endtask : t_defaults

    task automatic t_straps;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            {autoStrap, manStrap} = 2'(i);
            @(negedge clk);
            modeChk(i[1] ? 2'h3 : {1'b0, i[0]});
        end
    endtask : t_straps

    task automatic t_reg_modes;
        for (int i = 0; i < 3; i++)
        begin
            wrW({1'b1, 2'(i), 13'h0});
            modeChk(i == 2 ? 2'h3 : 2'(i));
            rdChk("mode image", {1'b1, 2'(i), 13'h0});
        end
    endtask : t_reg_modes

    task automatic t_ctrl_bits;
        wrW(16'hffff);
        ctrlChk(1'b1, 1'b1);
        rdChk("all ones", 16'hcc00);
        wrW(16'h0800);
        ctrlChk(1'b1, 1'b0);
        wrW(16'h0400);
        ctrlChk(1'b0, 1'b1);
    endtask : t_ctrl_bits

    task automatic t_addr;
        logic [15:0] d;
        logic        v;
        host.wr(portAddr ^ 5'h01, 5'h1b, 16'h8800);
        host.wr(portAddr, 5'h1a, 16'h8800);
        rdChk("foreign writes", 16'h0400);
        host.rd(portAddr ^ 5'h01, 5'h1b, d, v);
        check("foreign read valid", 16'h0000, {15'h0, v});
        @(negedge clk);
        portAddr = 5'h12;
        wrW(16'h0800);
        rdChk("moved address", 16'h0800);
    endtask : t_addr

    task automatic t_polarity;
        pol = 1'b1;
        repeat (3) @(negedge clk);
        rdChk("reversed", 16'h0810);
        pol = 1'b0;
        repeat (3) @(negedge clk);
        wrW(16'h0010);
        rdChk("normal", 16'h0000);
    endtask : t_polarity

    task automatic t_port_reset;
        wrW(16'hcc00);
        @(negedge clk);
        portRst = 1'b1;
        @(negedge clk);
        portRst = 1'b0;
        rdChk("basic bit clear", 16'hcc00);
        @(negedge clk);
        {portRst, basicRst} = 2'b11;
        @(negedge clk);
        {portRst, basicRst} = 2'b00;
        ctrlChk(1'b0, 1'b0);
        rdChk("port reset", 16'h8000);
        wrW(16'h6c00);
        @(negedge clk);
        sysRst = 1'b1;
        repeat (3) @(negedge clk);
        sysRst = 1'b0;
        rdChk("hard reset", 16'h0000);
    endtask : t_port_reset

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // Ceiling well above the hundred or so cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            stop_test();
        end
    end

    initial
    begin
        repeat (16) @(negedge clk);
        sysRst = 1'b0;
        t_defaults();
        t_straps();
        t_reg_modes();
        t_ctrl_bits();
        t_addr();
        t_polarity();
        t_port_reset();
        stop_test();
    end
endmodule : pxc_special_ctrl_tb_top
